// [rtl/cdt_pkg.sv]
// Summary of operation
// - Delay deactivation by off count ticks.
// - Emergency deactivations skip the off delay.
// - Off count zero adds no delay.
// - Sample supply good at check expiry.
// - Supply bad at expiry clears supply select.
// - Check count zero never times out.
// - Count zero: need ready start and ready.
// - Detection runs without the card clock.
// - Power down bypasses debounce, keeps presence.
// - Debounce needs 64 ms stable assertion.
// - Debounce counts the 1 kHz tick.
// - Removal clears card present at once.
// - Detect enable turns detection on, resets zero.
// - Polarity one: high means card present.
// - Pull-up enable is active low.
// - Pull-down enable one switches pull-down on.
// - Card present read-only; changes raise events.
// - Nonzero select starts activation and check timer.
// - Check timeout with bad supply raises event.
// - Ready start waits for supply good.
package cdt_pkg;
  localparam logic [15:0] CDT_ADDR_TIMERS = 16'hFE04;
  localparam logic [15:0] CDT_ADDR_CARD   = 16'hFE05;
  localparam logic [15:0] CDT_ADDR_SUPPLY = 16'hFE10;
  localparam logic [7:0]  CDT_TIMERS_RESET = 8'h0F;
  localparam logic [7:0]  CDT_CARD_RESET   = 8'h00;
  localparam int CDT_CARD_PRESENT_BIT  = 0;
  localparam int CDT_PULLDOWN_BIT      = 1;
  localparam int CDT_PULLUP_N_BIT      = 2;
  localparam int CDT_POLARITY_BIT      = 3;
  localparam int CDT_DETECT_EN_BIT     = 6;
  localparam int CDT_DEBOUNCE_BIT      = 7;
  localparam int CDT_SUP_READY_START_BIT = 4;
  localparam int CDT_SUP_SELECT_LSB    = 6;
  localparam int CDT_CLK_HZ            = 25000000;
  localparam int CDT_SLOW_HZ           = 32768;
  localparam int CDT_KEY_HZ            = 1000;
  localparam int CDT_SLOW_DIV = CDT_CLK_HZ / CDT_SLOW_HZ;
  localparam int CDT_KEY_DIV  = CDT_CLK_HZ / CDT_KEY_HZ;
  localparam int CDT_DEBOUNCE_MS       = 64;
  localparam logic [6:0] CDT_DEBOUNCE_TICKS = 7'(CDT_DEBOUNCE_MS * CDT_KEY_HZ / 1000);
  typedef enum logic [4:0]
  {
    CDT_IDLE   = 5'b00001,
    CDT_CHECK  = 5'b00010,
    CDT_WAIT   = 5'b00100,
    CDT_ON     = 5'b01000,
    CDT_OFFDLY = 5'b10000
  } cdt_state_type;
endpackage

// [rtl/cdt_tick_if.sv]
`timescale 1ns/10ps
interface cdt_tick_if;
  logic slowTick;
  logic keyTick;
  modport source (output slowTick, output keyTick);
  modport sink (input slowTick, input keyTick);
endinterface

// [rtl/cdt_tick_gen.sv]
`timescale 1ns/10ps
module cdt_tick_gen
  import cdt_pkg::*;
(
  // System.
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  // Ticks.
  cdt_tick_if.source  ticks
);
  typedef struct packed
  {
    logic [15:0] slowCnt;
    logic [15:0] keyCnt;
    logic        slowTick;
    logic        keyTick;
  } cdt_tick_state_type;
  cdt_tick_state_type st;
  cdt_tick_state_type next_st;
  always_comb
  begin
    next_st = st;
    next_st.slowTick = 1'b0;
    next_st.keyTick = 1'b0;
    if (st.slowCnt == 16'(CDT_SLOW_DIV - 1))
    begin
      next_st.slowCnt = 16'h0000;
      next_st.slowTick = 1'b1;
    end
    else
      next_st.slowCnt = st.slowCnt + 16'h0001;
    if (st.keyCnt == 16'(CDT_KEY_DIV - 1))
    begin
      next_st.keyCnt = 16'h0000;
      next_st.keyTick = 1'b1;
    end
    else
      next_st.keyCnt = st.keyCnt + 16'h0001;
  end
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  assign ticks.slowTick = st.slowTick;
  assign ticks.keyTick = st.keyTick;
endmodule

// [rtl/cdt_detect.sv]
`timescale 1ns/10ps
module cdt_detect
  import cdt_pkg::*;
(
  // System.
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  cdt_tick_if.sink    ticks,
  // Control.
  input  wire logic   cardPin,
  input  wire logic   detectEnable,
  input  wire logic   debounceEnable,
  input  wire logic   detectPolarity,
  input  wire logic   powerDown,
  // Status.
  output logic        cardPresent,
  output logic        cardEvent
);
  typedef struct packed
  {
    logic       sync1;
    logic       sync2;
    logic       level;
    logic [6:0] count;
    logic       present;
    logic       event_;
  } cdt_det_state_type;
  cdt_det_state_type st;
  cdt_det_state_type next_st;
  logic asserted;
  // Runs on the system clock only, so a stopped card clock does not stall presence.
  always_comb
  begin
    next_st = st;
    next_st.sync1 = cardPin;
    next_st.sync2 = st.sync1;
    next_st.level = st.sync2;
    next_st.event_ = 1'b0;
    asserted = detectEnable && (st.sync2 == detectPolarity);
    if (st.sync2 != st.level)
      next_st.count = 7'h00;
    else if (ticks.keyTick && st.count != CDT_DEBOUNCE_TICKS)
      next_st.count = st.count + 7'h01;
    if (!asserted)
      next_st.present = 1'b0;
    else if (!debounceEnable || powerDown)
      next_st.present = 1'b1;
    else if (st.count == CDT_DEBOUNCE_TICKS && st.sync2 == st.level)
      next_st.present = 1'b1;
    if (next_st.present != st.present)
      next_st.event_ = 1'b1;
  end
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  assign cardPresent = st.present;
  assign cardEvent = st.event_;
endmodule

// [rtl/cdt_top.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module cdt_top
  import cdt_pkg::*;
(
  // System.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Register port.
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // Card detect pin and pad controls.
  input  wire logic        card_detect_pin,
  output logic             pullupEnableN,
  output logic             pulldownEnable,
  // Supply supervision.
  input  wire logic        supply_good,
  input  wire logic        readyIn,
  input  wire logic        core_supply_fault,
  input  wire logic        power_down,
  output logic      [1:0]  supplySelect,
  output logic             activationGo,
  output logic             deactivateStart,
  output logic             cardEvent
);
  typedef struct packed
  {
    logic [7:0]    timers;
    logic [7:0]    card;
    logic [1:0]    select;
    logic          readyStart;
    cdt_state_type state;
    logic [3:0]    tickCnt;
    logic          readyPrev;
    logic          go;
    logic          deact;
    logic          event_;
    logic [7:0]    rdata;
  } cdt_top_state_type;
  cdt_top_state_type st;
  cdt_top_state_type next_st;
  logic cardPresent;
  logic detEvent;
  cdt_tick_if tickBus ();
  cdt_tick_gen u_ticks
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ticks   (tickBus)
  );
  cdt_detect u_detect
  (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .ticks          (tickBus),
    .cardPin        (card_detect_pin),
    .detectEnable   (st.card[CDT_DETECT_EN_BIT]),
    .debounceEnable (st.card[CDT_DEBOUNCE_BIT]),
    .detectPolarity (st.card[CDT_POLARITY_BIT]),
    .powerDown      (power_down),
    .cardPresent    (cardPresent),
    .cardEvent      (detEvent)
  );
  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.go = 1'b0;
    next_st.deact = 1'b0;
    next_st.event_ = detEvent;
    next_st.readyPrev = readyIn;
    next_st.rdata = 8'h00;
    if (regRead)
    begin
      if (regAddr == CDT_ADDR_TIMERS)
        next_st.rdata = st.timers;
      else if (regAddr == CDT_ADDR_CARD)
        next_st.rdata = {st.card[7:6], 2'b00, st.card[3:1], cardPresent};
      else if (regAddr == CDT_ADDR_SUPPLY)
        next_st.rdata = {st.select, ~core_supply_fault, st.readyStart, supply_good, 3'b000};
    end
    // Software is expected to set the other card bits before detect enable.
    if (regWrite && regAddr == CDT_ADDR_TIMERS)
      next_st.timers = regWdata;
    if (regWrite && regAddr == CDT_ADDR_CARD)
      next_st.card = {regWdata[7:6], 2'b00, regWdata[3:1], 1'b0};
    if (regWrite && regAddr == CDT_ADDR_SUPPLY)
    begin
      next_st.select = regWdata[CDT_SUP_SELECT_LSB +: 2];
      next_st.readyStart = regWdata[CDT_SUP_READY_START_BIT];
    end
    case (st.state)
      CDT_IDLE:
        if (next_st.select != 2'b00)
        begin
          next_st.tickCnt = 4'h0;
          next_st.state = CDT_CHECK;
        end
      CDT_CHECK:
        if (next_st.select == 2'b00)
          next_st.state = CDT_IDLE;
        else if (st.timers[3:0] == 4'h0)
        begin
          // A zero count never expires; only ready start with ready rising proceeds.
          if (st.readyStart && readyIn && !st.readyPrev && supply_good)
          begin
            next_st.go = 1'b1;
            next_st.state = CDT_ON;
          end
        end
        else if (st.readyStart && supply_good)
        begin
          next_st.go = 1'b1;
          next_st.state = CDT_ON;
        end
        else if (tickBus.keyTick == 1'b0 && tickBus.slowTick)
        begin
          if (st.tickCnt + 4'h1 == st.timers[3:0])
          begin
            if (supply_good)
            begin
              next_st.go = 1'b1;
              next_st.state = CDT_ON;
            end
            else
            begin
              next_st.select = 2'b00;
              next_st.event_ = 1'b1;
              next_st.deact = 1'b1;
              next_st.state = CDT_IDLE;
            end
          end
          else
            next_st.tickCnt = st.tickCnt + 4'h1;
        end
      CDT_ON:
        if (next_st.select == 2'b00)
        begin
          next_st.tickCnt = 4'h0;
          if (st.timers[7:4] == 4'h0)
          begin
            next_st.deact = 1'b1;
            next_st.state = CDT_IDLE;
          end
          else
            next_st.state = CDT_OFFDLY;
        end
      CDT_OFFDLY:
        if (tickBus.slowTick)
        begin
          if (st.tickCnt + 4'h1 == st.timers[7:4])
          begin
            next_st.deact = 1'b1;
            next_st.state = CDT_IDLE;
          end
          else
            next_st.tickCnt = st.tickCnt + 4'h1;
        end
      default:
        next_st.state = CDT_IDLE;
    endcase
    // Emergencies win over any programmed delay and any software select write, except in idle where they are not applied.
    if ((core_supply_fault || detEvent) && st.state != CDT_IDLE)
    begin
      next_st.select = 2'b00;
      next_st.deact = 1'b1;
      next_st.state = CDT_IDLE;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      st <= '0;
      st.timers <= CDT_TIMERS_RESET;
      st.card <= CDT_CARD_RESET;
      st.state <= CDT_IDLE;
    end
    else
      st <= next_st;
  //////////////////////////////////////////////////////////////////////////////
  assign regRdata = st.rdata;
  assign pullupEnableN = st.card[CDT_PULLUP_N_BIT];
  assign pulldownEnable = st.card[CDT_PULLDOWN_BIT];
  assign supplySelect = st.select;
  assign activationGo = st.go;
  assign deactivateStart = st.deact;
  assign cardEvent = st.event_;
endmodule

// [tb/cdt_card_switch.sv]
`timescale 1ns/10ps
module cdt_card_switch
(
  // Pad controls.
  input wire logic pullupEnableN,
  input wire logic pulldownEnable,
  // Switch.
  input wire logic closed,
  input wire logic closedLevel,
  output logic     pin
);
  // A floating pin shows the opposite level so it never looks like a closed switch.
  always_comb
    if (closed)
      pin = closedLevel;
    else if (!pullupEnableN)
      pin = 1'b1;
    else if (pulldownEnable)
      pin = 1'b0;
    else
      pin = ~closedLevel;
endmodule

// [tb/cdt_top_sva.sv]
`timescale 1ns/10ps
module cdt_top_sva
  import cdt_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  input wire logic        pullupEnableN,
  input wire logic        pulldownEnable,
  input wire logic        supply_good,
  input wire logic        core_supply_fault,
  input wire logic [1:0]  supplySelect,
  input wire logic        activationGo,
  input wire logic        deactivateStart,
  input wire logic        cardEvent
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [3:0] offCount;
  logic       onState;
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      offCount <= 4'h0;
      onState  <= 1'b0;
    end
    else
    begin
      if (regWrite && regAddr == CDT_ADDR_TIMERS)
        offCount <= regWdata[7:4];
      if (deactivateStart)
        onState <= 1'b0;
      else if (activationGo)
        onState <= 1'b1;
    end
  sequence s_cardWr;
    regWrite && regAddr == CDT_ADDR_CARD;
  endsequence
  sequence s_supWr;
    regWrite && regAddr == CDT_ADDR_SUPPLY;
  endsequence
  property p_pullup;
    s_cardWr |=> pullupEnableN == $past(regWdata[CDT_PULLUP_N_BIT]);
  endproperty
  property p_pulldown;
    s_cardWr |=> pulldownEnable == $past(regWdata[CDT_PULLDOWN_BIT]);
  endproperty
  property p_select;
    s_supWr ##0 (regWdata[7:6] != 2'b00 && supplySelect == 2'b00 && !onState && !core_supply_fault)
      |=> supplySelect == $past(regWdata[7:6]);
  endproperty
  property p_offZero;
    s_supWr ##0 (regWdata[7:6] == 2'b00 && onState && offCount == 4'h0) |-> ##[1:3] deactivateStart;
  endproperty
  property p_fault;
    $rose(core_supply_fault) && onState |-> ##[0:3] deactivateStart;
  endproperty
  property p_goGood;
    activationGo |-> $past(supply_good);
  endproperty
  property p_evtPulse;
    cardEvent |=> !cardEvent;
  endproperty
  // The read-back of the pad bits must follow the pad outputs that stood at the read edge.
  property p_rsvd;
    regRead && regAddr == CDT_ADDR_CARD |=> regRdata[5:4] == 2'b00 &&
      regRdata[CDT_PULLUP_N_BIT] == $past(pullupEnableN) && regRdata[CDT_PULLDOWN_BIT] == $past(pulldownEnable);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up control mismatch");
  a_pulldown: assert property (p_pulldown) else $error("pull-down control mismatch");
  a_select: assert property (p_select) else $error("supply select not taken");
  a_offZero: assert property (p_offZero) else $error("zero off delay late");
  a_fault: assert property (p_fault) else $error("fault deactivation late");
  a_goGood: assert property (p_goGood) else $error("activation without supply good");
  a_evtPulse: assert property (p_evtPulse) else $error("card event too long");
  a_rsvd: assert property (p_rsvd) else $error("card register read-back mismatch");
endmodule
bind cdt_top cdt_top_sva chk_u (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pullupEnableN(pullupEnableN),
  .pulldownEnable(pulldownEnable), .supply_good(supply_good), .core_supply_fault(core_supply_fault),
  .supplySelect(supplySelect), .activationGo(activationGo), .deactivateStart(deactivateStart),
  .cardEvent(cardEvent));

// [tb/cdt_top_tb.sv]
`timescale 1ns/10ps
module cdt_top_tb
  import cdt_pkg::*;
;
  logic        clk_sys = 0, nrst = 0, regWrite = 0, regRead = 0, cardPin, closed = 0, closedLevel = 1;
  logic        supply_good = 0, readyIn = 0, core_supply_fault = 0, power_down = 0;
  logic [15:0] regAddr = 0;
  logic [7:0]  regWdata = 0, regRdata, d;
  logic [1:0]  supplySelect;
  logic        pullupEnableN, pulldownEnable, activationGo, deactivateStart, cardEvent;
  logic [2:0]  pul;
  int          errors = 0, total_checks = 0;
  assign pul = {cardEvent, deactivateStart, activationGo};
  cdt_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .card_detect_pin(cardPin), .pullupEnableN(pullupEnableN),
    .pulldownEnable(pulldownEnable), .supply_good(supply_good), .readyIn(readyIn),
    .core_supply_fault(core_supply_fault), .power_down(power_down), .supplySelect(supplySelect),
    .activationGo(activationGo), .deactivateStart(deactivateStart), .cardEvent(cardEvent));
  cdt_card_switch sw_u (.pullupEnableN(pullupEnableN), .pulldownEnable(pulldownEnable), .closed(closed),
    .closedLevel(closedLevel), .pin(cardPin));
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("Checks made %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask
  // A pulse that never comes ends the run rather than hanging it.
  task waitP(input int k, input int lim);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (pul[k] !== 1'b1 && n < lim);
    chk("pulse", 8'(pul[k]), 8'h01);
    if (pul[k] !== 1'b1)
      close_out;
  endtask
  task quiet(input int k, input int lim);
    logic hit;
    hit = 1'b0;
    repeat (lim) @(negedge clk_sys) if (pul[k] === 1'b1) hit = 1'b1;
    chk("no pulse", 8'(hit), 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task reset_values;
    rd(CDT_ADDR_CARD);
    chk("card reg", d, CDT_CARD_RESET);
    rd(CDT_ADDR_TIMERS);
    chk("timers reg", d, CDT_TIMERS_RESET);
  endtask
  task detect_both_polarities;
    logic [7:0] cfg;
    for (int p = 0; p < 2; p++)
    begin
      cfg = p ? 8'h4E : 8'h40;
      wr(CDT_ADDR_CARD, cfg & 8'hBF);
      wr(CDT_ADDR_CARD, cfg);
      // The pad outputs settle only after the write edge, so look half a cycle later.
      @(negedge clk_sys);
      chk("pull-up", 8'(pullupEnableN), 8'(cfg[2]));
      chk("pull-down", 8'(pulldownEnable), 8'(cfg[1]));
      @(posedge clk_sys) closedLevel <= p[0];
      @(posedge clk_sys) closed <= 1'b1;
      waitP(2, 20);
      rd(CDT_ADDR_CARD);
      chk("present", d, cfg | 8'h01);
      @(posedge clk_sys) closed <= 1'b0;
      waitP(2, 20);
      rd(CDT_ADDR_CARD);
      chk("absent", d, cfg);
    end
  endtask
  task debounce_and_power_down;
    wr(CDT_ADDR_CARD, 8'h8E);
    wr(CDT_ADDR_CARD, 8'hCE);
    @(posedge clk_sys) closed <= 1'b1;
    quiet(2, 300);
    rd(CDT_ADDR_CARD);
    chk("debouncing", d, 8'hCE);
    @(posedge clk_sys) power_down <= 1'b1;
    waitP(2, 20);
    @(posedge clk_sys) closed <= 1'b0;
    waitP(2, 20);
    @(posedge clk_sys) power_down <= 1'b0;
    wr(CDT_ADDR_CARD, 8'h00);
  endtask
  task supply_timed;
    wr(CDT_ADDR_TIMERS, 8'h02);
    @(posedge clk_sys) supply_good <= 1'b1;
    wr(CDT_ADDR_SUPPLY, 8'h40);
    quiet(0, 700);
    waitP(0, 3000);
    chk("select", 8'(supplySelect), 8'h01);
    wr(CDT_ADDR_SUPPLY, 8'h00);
    waitP(1, 5);
    @(posedge clk_sys) supply_good <= 1'b0;
    wr(CDT_ADDR_SUPPLY, 8'h40);
    waitP(2, 3000);
    chk("deactivate", 8'(deactivateStart), 8'h01);
    rd(CDT_ADDR_SUPPLY);
    chk("select cleared", d, 8'h20);
  endtask
  // A nonzero off count makes a late deactivation here a real failure of the bypass.
  task supply_fault;
    wr(CDT_ADDR_TIMERS, 8'h32);
    @(posedge clk_sys) supply_good <= 1'b1;
    wr(CDT_ADDR_SUPPLY, 8'h40);
    waitP(0, 3000);
    @(posedge clk_sys) core_supply_fault <= 1'b1;
    waitP(1, 5);
    @(posedge clk_sys) core_supply_fault <= 1'b0;
    wr(CDT_ADDR_SUPPLY, 8'h00);
  endtask
  task supply_no_timeout;
    wr(CDT_ADDR_TIMERS, 8'h00);
    @(posedge clk_sys) supply_good <= 1'b0;
    wr(CDT_ADDR_SUPPLY, 8'h50);
    quiet(1, 2000);
    @(posedge clk_sys) supply_good <= 1'b1;
    readyIn <= 1'b1;
    waitP(0, 20);
    wr(CDT_ADDR_SUPPLY, 8'h00);
  endtask
  // Three off ticks take between two and three slow periods, as the first tick may come at once.
  task supply_off_delay;
    wr(CDT_ADDR_TIMERS, 8'h32);
    wr(CDT_ADDR_SUPPLY, 8'h50);
    waitP(0, 5);
    wr(CDT_ADDR_SUPPLY, 8'h00);
    quiet(1, 1500);
    waitP(1, 1000);
    wr(CDT_ADDR_CARD, 8'h0E);
    wr(CDT_ADDR_CARD, 8'h4E);
    wr(CDT_ADDR_SUPPLY, 8'h50);
    waitP(0, 5);
    @(posedge clk_sys) closed <= 1'b1;
    waitP(1, 8);
    chk("select dropped", 8'(supplySelect), 8'h00);
    @(posedge clk_sys) closed <= 1'b0;
    waitP(2, 20);
    wr(CDT_ADDR_CARD, 8'h00);
    wr(CDT_ADDR_SUPPLY, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    reset_values;
    detect_both_polarities;
    debounce_and_power_down;
    supply_timed;
    supply_fault;
    supply_no_timeout;
    supply_off_delay;
    close_out;
  end
endmodule
